// >>> inc/bcgir_consts.vh
// Constants for the bridge control, GPIO and interrupt byte register block
// Assumes inclusion by the register block, its checker and the bench
`ifndef BCGIR_CONSTS_VH
`define BCGIR_CONSTS_VH
// ==========================================================
// Register offsets
`define BCGIR_OFS_CTRL       8'h78
`define BCGIR_OFS_GPIO       8'h78
`define BCGIR_OFS_IRQB       8'h7c
`define BCGIR_OFS_ISTAT      8'h8c
`define BCGIR_OFS_IMASK      8'h90
// ==========================================================
// Bridge control field positions
`define BCGIR_VGA_LO         4
`define BCGIR_VGA_HI         5
`define BCGIR_VGA16          6
`define BCGIR_MAMODE         7
`define BCGIR_PTMO           8
`define BCGIR_STMO           9
`define BCGIR_TMOSTAT        10
`define BCGIR_TMOERR         11
// ==========================================================
// GPIO field positions
`define BCGIR_GO_CLR_LO      12
`define BCGIR_GO_SET_LO      16
`define BCGIR_GE_CLR_LO      20
`define BCGIR_GE_SET_LO      24
`define BCGIR_GIN_LO         28
// ==========================================================
// Codes and reset values
`define BCGIR_VGA_OFF        2'h0
`define BCGIR_VGA_P2S        2'h1
`define BCGIR_VGA_S2P        2'h2
`define BCGIR_PIN_FWD        8'h01
`define BCGIR_PIN_REV        8'h00
`define BCGIR_RST_BYTE       8'h00
`define BCGIR_ALL_ONES       32'hffff_ffff
`define BCGIR_LONG_EXP       15
`define BCGIR_SHORT_EXP      10
`endif

// >>> rtl/bcgir_regs.v
// Upper bridge control fields, GPIO set/clear, secondary interrupt bytes
// Assumes synchronous inputs on clk; decode and timer requests come from the bridge core
`include "bcgir_consts.vh"

// Functional notes
// - VGA code 00 forwards nothing
// - VGA code 01 forwards primary to secondary
// - VGA code 10 forwards secondary to primary
// - VGA I/O decode uses 10 or 16 bits
// - Hidden master abort: all-ones reads, drop writes
// - Reported master abort: target abort or system error
// - Primary timer length select, read-only forward
// - Secondary timer length select, read-only reverse
// - Discard expiry sets write-one-clear status bit
// - Discard expiry error signalling when enabled, none in PCI-X mode
// - Four GPIO bits with set and clear fields
// - Read-write secondary interrupt line byte
// - Interrupt pin byte 01h forward, 00h reverse
module bcgir_regs #(
  parameter GPIO_W = 4
) (
  input  wire               clk,
  input  wire               rst,
  input  wire [7:0]         addr,
  input  wire [31:0]        wdata,
  input  wire               wr,
  input  wire               rd,
  output reg  [31:0]        rdata,
  input  wire               fwd_mode,
  input  wire               pcix_mode,
  input  wire               serr_en,
  input  wire               vga_mem_hit,
  input  wire               vga_io_hit,
  input  wire               vga_from_sec,
  input  wire [15:0]        vga_io_addr,
  output reg                vga_claim,
  input  wire               mabort,
  input  wire               mabort_is_read,
  input  wire               tabort_possible,
  output reg  [31:0]        mabort_rdata,
  output reg                mabort_drop,
  output reg                tabort_out,
  input  wire               pri_tmr_start,
  input  wire               sec_tmr_start,
  input  wire               dc_discarded,
  output reg                pri_tmr_exp,
  output reg                sec_tmr_exp,
  output reg                err_msg_out,
  output reg                serr_out,
  input  wire [GPIO_W-1:0]  gpio_in,
  output reg  [GPIO_W-1:0]  gpio_out,
  output reg  [GPIO_W-1:0]  gpio_oe,
  output reg                irq
);

  // ==========================================================
  // Helpers
  function [GPIO_W-1:0] setclr;
    input [GPIO_W-1:0] cur;
    input [GPIO_W-1:0] s;
    input [GPIO_W-1:0] c;
    begin
      setclr = (cur | (s & ~c)) & ~(c & ~s);
    end
  endfunction

  function [15:0] tmr_len;
    input sel;
    begin
      tmr_len = sel ? (16'h0001 << `BCGIR_SHORT_EXP) : (16'h0001 << `BCGIR_LONG_EXP);
    end
  endfunction

  // ==========================================================
  // State
  reg  [1:0]         vga_reg;
  reg                vga16_reg;
  reg                mamode_reg;
  reg                ptmo_reg;
  reg                stmo_reg;
  reg                tmostat_reg;
  reg                tmoerr_reg;
  reg  [7:0]         line_reg;
  reg  [1:0]         istat_reg;
  reg  [1:0]         imask_reg;
  reg  [15:0]        pcnt_reg;
  reg  [15:0]        scnt_reg;
  reg                prun_reg;
  reg                srun_reg;
  reg  [31:0]        rd_next;
  reg                vga_next;
  wire               pexp;
  wire               sexp;
  wire               expire;
  wire               dc_evt;
  wire [1:0]         ev;
  wire               wr_ctrl;
  wire               wr_gpio;
  wire               wr_istat;

  assign wr_ctrl  = wr && (addr == `BCGIR_OFS_CTRL);
  assign wr_gpio  = wr && (addr == `BCGIR_OFS_GPIO);
  assign wr_istat = wr && (addr == `BCGIR_OFS_ISTAT);
  assign pexp     = prun_reg && (pcnt_reg == 16'h0001);
  assign sexp     = srun_reg && (scnt_reg == 16'h0001);
  assign expire   = pexp | sexp;
  assign dc_evt   = expire & dc_discarded;
  assign ev       = {pexp | sexp, dc_evt};

  // ==========================================================
  // Control, interrupt line and interrupt mask register writes
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      vga_reg    <= `BCGIR_VGA_OFF;
      vga16_reg  <= 1'b0;
      mamode_reg <= 1'b0;
      ptmo_reg   <= 1'b0;
      stmo_reg   <= 1'b0;
      tmoerr_reg <= 1'b0;
      line_reg   <= `BCGIR_RST_BYTE;
      imask_reg  <= 2'h0;
    end else begin
      if (wr_ctrl) begin
        vga_reg    <= wdata[`BCGIR_VGA_HI:`BCGIR_VGA_LO];
        vga16_reg  <= wdata[`BCGIR_VGA16];
        mamode_reg <= wdata[`BCGIR_MAMODE];
        if (!fwd_mode) begin
          ptmo_reg <= wdata[`BCGIR_PTMO];
        end
        if (fwd_mode) begin
          stmo_reg <= wdata[`BCGIR_STMO];
        end
        tmoerr_reg <= wdata[`BCGIR_TMOERR];
      end
      if (wr && (addr == `BCGIR_OFS_IRQB)) begin
        line_reg <= wdata[7:0];
      end
      if (wr && (addr == `BCGIR_OFS_IMASK)) begin
        imask_reg <= wdata[1:0];
      end
    end
  end

  // ==========================================================
  // Discard timers
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pcnt_reg <= 16'h0000;
      scnt_reg <= 16'h0000;
      prun_reg <= 1'b0;
      srun_reg <= 1'b0;
    end else begin
      if (pri_tmr_start) begin
        pcnt_reg <= tmr_len(ptmo_reg && !fwd_mode);
        prun_reg <= 1'b1;
      end else if (prun_reg) begin
        pcnt_reg <= pcnt_reg - 16'h0001;
        prun_reg <= !pexp;
      end
      if (sec_tmr_start) begin
        scnt_reg <= tmr_len(stmo_reg && fwd_mode);
        srun_reg <= 1'b1;
      end else if (srun_reg) begin
        scnt_reg <= scnt_reg - 16'h0001;
        srun_reg <= !sexp;
      end
    end
  end

  // ==========================================================
  // Status, interrupts, error signalling
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tmostat_reg <= 1'b0;
      istat_reg   <= 2'h0;
      pri_tmr_exp <= 1'b0;
      sec_tmr_exp <= 1'b0;
      err_msg_out <= 1'b0;
      serr_out    <= 1'b0;
      tabort_out  <= 1'b0;
      irq         <= 1'b0;
    end else begin
      if (dc_evt) begin
        tmostat_reg <= 1'b1;
      end else if (wr_ctrl && wdata[`BCGIR_TMOSTAT]) begin
        tmostat_reg <= 1'b0;
      end
      istat_reg   <= ev | (istat_reg & ~({2{wr_istat}} & wdata[1:0]));
      irq         <= |((ev | istat_reg) & imask_reg);
      pri_tmr_exp <= pexp;
      sec_tmr_exp <= sexp;
      err_msg_out <= expire && tmoerr_reg && fwd_mode && !pcix_mode;
      tabort_out  <= mabort && mamode_reg && tabort_possible;
      serr_out    <= (expire && tmoerr_reg && !fwd_mode && !pcix_mode) ||
                     (mabort && mamode_reg && !tabort_possible && serr_en);
    end
  end

  // ==========================================================
  // Master abort hiding
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      mabort_rdata <= 32'h0000_0000;
      mabort_drop  <= 1'b0;
    end else begin
      mabort_rdata <= (mabort && !mamode_reg && mabort_is_read) ? `BCGIR_ALL_ONES
                                                               : 32'h0000_0000;
      mabort_drop  <= mabort && !mamode_reg && !mabort_is_read;
    end
  end

  // ==========================================================
  // GPIO
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      gpio_out <= {GPIO_W{1'b0}};
      gpio_oe  <= {GPIO_W{1'b0}};
    end else if (wr_gpio) begin
      gpio_out <= setclr(gpio_out, wdata[`BCGIR_GO_SET_LO +: GPIO_W],
                         wdata[`BCGIR_GO_CLR_LO +: GPIO_W]);
      gpio_oe  <= setclr(gpio_oe, wdata[`BCGIR_GE_SET_LO +: GPIO_W],
                         wdata[`BCGIR_GE_CLR_LO +: GPIO_W]);
    end
  end

  // ==========================================================
  // VGA claim decode
  always @* begin
    vga_next = 1'b0;
    if (vga_reg == `BCGIR_VGA_P2S) begin
      vga_next = !vga_from_sec;
    end else if (vga_reg == `BCGIR_VGA_S2P) begin
      vga_next = vga_from_sec;
    end
    // 10 or 16 bit I/O decode
    if (vga_io_hit && vga16_reg && (vga_io_addr[15:10] != 6'h00)) begin
      vga_next = 1'b0;
    end
    if (!vga_mem_hit && !vga_io_hit) begin
      vga_next = 1'b0;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      vga_claim <= 1'b0;
    end else begin
      vga_claim <= vga_next;
    end
  end

  // ==========================================================
  // Read data
  always @* begin
    rd_next = 32'h0000_0000;
    if (addr == `BCGIR_OFS_CTRL) begin
      rd_next[`BCGIR_VGA_HI:`BCGIR_VGA_LO] = vga_reg;
      rd_next[`BCGIR_VGA16]   = vga16_reg;
      rd_next[`BCGIR_MAMODE]  = mamode_reg;
      rd_next[`BCGIR_PTMO]    = ptmo_reg;
      rd_next[`BCGIR_STMO]    = stmo_reg;
      rd_next[`BCGIR_TMOSTAT] = tmostat_reg;
      rd_next[`BCGIR_TMOERR]  = tmoerr_reg;
    end else if (addr == `BCGIR_OFS_IRQB) begin
      rd_next[7:0]  = line_reg;
      rd_next[15:8] = fwd_mode ? `BCGIR_PIN_FWD : `BCGIR_PIN_REV;
    end else if (addr == `BCGIR_OFS_ISTAT) begin
      rd_next[1:0] = istat_reg;
    end else if (addr == `BCGIR_OFS_IMASK) begin
      rd_next[1:0] = imask_reg;
    end
    if (addr == `BCGIR_OFS_GPIO) begin
      rd_next[`BCGIR_GO_SET_LO +: GPIO_W] = gpio_out;
      rd_next[`BCGIR_GE_SET_LO +: GPIO_W] = gpio_oe;
      rd_next[`BCGIR_GIN_LO +: GPIO_W]    = gpio_in;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= 32'h0000_0000;
    end else begin
      rdata <= rd ? rd_next : 32'h0000_0000;
    end
  end

endmodule

// >>> tb/bcgir_regs_properties.sv
// Checker for the bridge control, GPIO and interrupt byte block
// Assumes the block ports as declared and the shared offset constants
`include "bcgir_consts.vh"
module bcgir_chk #(
  parameter GPIO_W = 4
) (
  input logic              clk,
  input logic              rst,
  input logic [7:0]        addr,
  input logic [31:0]       wdata,
  input logic              wr,
  input logic              rd,
  input logic [31:0]       rdata,
  input logic              fwd_mode,
  input logic              pcix_mode,
  input logic              serr_en,
  input logic              vga_mem_hit,
  input logic              vga_io_hit,
  input logic              vga_from_sec,
  input logic [15:0]       vga_io_addr,
  input logic              vga_claim,
  input logic              mabort,
  input logic              mabort_is_read,
  input logic              tabort_possible,
  input logic [31:0]       mabort_rdata,
  input logic              mabort_drop,
  input logic              tabort_out,
  input logic              pri_tmr_exp,
  input logic              sec_tmr_exp,
  input logic              err_msg_out,
  input logic              serr_out,
  input logic [GPIO_W-1:0] gpio_out,
  input logic [GPIO_W-1:0] gpio_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  // ========
  // Shadow of the control fields
  logic [11:4] sh;
  wire gp_wr = wr && addr == `BCGIR_OFS_GPIO;
  wire dir_ok = vga_from_sec ? sh[5:4] == `BCGIR_VGA_S2P : sh[5:4] == `BCGIR_VGA_P2S;
  always @(posedge clk or posedge rst) begin
    if (rst)
      sh <= 8'h00;
    else if (wr && addr == `BCGIR_OFS_CTRL)
      sh <= wdata[11:4];
  end
  function automatic logic [GPIO_W-1:0] gsc(input logic [GPIO_W-1:0] c, s, q);
    gsc = (q & ~(c & ~s)) | (s & ~c);
  endfunction
  // ========
  // Properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_vga_mem_dir: assert property (
    vga_mem_hit && !vga_io_hit |=> vga_claim == $past(dir_ok)) else $error("VGA mem claim");
  a_vga_io_width: assert property (
    vga_io_hit && !vga_mem_hit |=> vga_claim ==
      $past(dir_ok && (!sh[6] || vga_io_addr[15:10] == 6'h00))) else $error("VGA io claim");
  a_hide_read: assert property (
    mabort && mabort_is_read && !sh[7] |=> mabort_rdata == `BCGIR_ALL_ONES)
    else $error("Hidden read not all ones");
  a_hide_write_drop: assert property (
    mabort && !mabort_is_read && !sh[7] |=> mabort_drop && !tabort_out)
    else $error("Hidden write not dropped");
  a_report_tabort: assert property (
    mabort && sh[7] && tabort_possible |=> tabort_out && !mabort_drop)
    else $error("Target abort missing");
  a_report_serr: assert property (
    mabort && sh[7] && !tabort_possible && serr_en |=> serr_out) else $error("SERR missing");
  a_err_message: assert property (
    (pri_tmr_exp || sec_tmr_exp) && sh[11] && fwd_mode && !pcix_mode |-> ##[0:1] err_msg_out)
    else $error("Error message missing");
  a_serr_discard: assert property (
    (pri_tmr_exp || sec_tmr_exp) && sh[11] && !fwd_mode && !pcix_mode |-> serr_out)
    else $error("Discard SERR missing");
  a_pin_byte: assert property (
    rd && addr == `BCGIR_OFS_IRQB |=> rdata[15:8] ==
      ($past(fwd_mode) ? `BCGIR_PIN_FWD : `BCGIR_PIN_REV)) else $error("Pin byte wrong");
  a_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0000_0000)
    else $error("Read data not idle");
  a_gpio_out_upd: assert property (
    gp_wr |=> gpio_out == gsc($past(wdata[`BCGIR_GO_CLR_LO +: GPIO_W]),
      $past(wdata[`BCGIR_GO_SET_LO +: GPIO_W]), $past(gpio_out))) else $error("GPIO out");
  a_gpio_oe_upd: assert property (
    gp_wr |=> gpio_oe == gsc($past(wdata[`BCGIR_GE_CLR_LO +: GPIO_W]),
      $past(wdata[`BCGIR_GE_SET_LO +: GPIO_W]), $past(gpio_oe))) else $error("GPIO oe");
endmodule

bind bcgir_regs bcgir_chk #(.GPIO_W(GPIO_W)) u_chk (.clk, .rst, .addr, .wdata, .wr, .rd,
  .rdata, .fwd_mode, .pcix_mode, .serr_en, .vga_mem_hit, .vga_io_hit, .vga_from_sec,
  .vga_io_addr, .vga_claim, .mabort, .mabort_is_read, .tabort_possible, .mabort_rdata,
  .mabort_drop, .tabort_out, .pri_tmr_exp, .sec_tmr_exp, .err_msg_out, .serr_out,
  .gpio_out, .gpio_oe);

// >>> tb/bcgir_pin_model.sv
// Model of the board pins feeding the general-purpose inputs
// Assumes the bench picks the levels, on the block clock
module bcgir_pin_model (
  input  logic       clk,
  input  logic [3:0] lvl,
  output logic [3:0] gpio_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial gpio_in = 4'h0;
  always @(posedge clk) begin
    gpio_in <= lvl;
  end
endmodule

// >>> tb/tb_top.sv
// Self-checking bench for the bridge control, GPIO and interrupt byte block
// Assumes the block header as delivered and a pin model on the GPIO inputs
`include "bcgir_consts.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0, rst = 1, wr = 0, rd = 0, fwd = 1, mab = 0, mrd = 0, tpos = 0;
  logic        mhit = 0, iohit = 0, fsec = 0, ps = 0, ss = 0, dcd = 0, sen = 1, pcx = 0;
  logic        claim, mdrop, tab, pexp, sexp, errm, serr, irq;
  logic [7:0]  addr = 0;
  logic [15:0] ioa = 0;
  logic [31:0] wdata = 0, rdata, mrdata, v, r, w;
  logic [3:0]  lvl = 0, gin, go, goe, eo = 0, eoe = 0;
  int          mismatches = 0, check_count = 0, n;
  always #12.5 clk = ~clk;
  bcgir_pin_model pins (.clk(clk), .lvl(lvl), .gpio_in(gin));
  bcgir_regs dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .fwd_mode(fwd), .pcix_mode(pcx), .serr_en(sen), .vga_mem_hit(mhit),
    .vga_io_hit(iohit), .vga_from_sec(fsec), .vga_io_addr(ioa), .vga_claim(claim),
    .mabort(mab), .mabort_is_read(mrd), .tabort_possible(tpos), .mabort_rdata(mrdata),
    .mabort_drop(mdrop), .tabort_out(tab), .pri_tmr_start(ps), .sec_tmr_start(ss),
    .dc_discarded(dcd), .pri_tmr_exp(pexp), .sec_tmr_exp(sexp), .err_msg_out(errm),
    .serr_out(serr), .gpio_in(gin), .gpio_out(go), .gpio_oe(goe), .irq(irq));
  // ========
  // Bus tasks and expectations
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got %h want %h", $time, got, exp);
    end
  endtask
  task wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) begin
      addr <= a;
      wdata <= d;
      wr <= 1;
    end
    @(posedge clk) wr <= 0;
  endtask
  task rreg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk) begin
      addr <= a;
      rd <= 1;
    end
    @(posedge clk) rd <= 0;
    #1 d = rdata;
  endtask
  function logic vexp(input logic [1:0] m, input logic s, v16, io, input logic [15:0] a);
    vexp = (s ? m == `BCGIR_VGA_S2P : m == `BCGIR_VGA_P2S) && !(io && v16 && a[15:10] != 0);
  endfunction
  function logic [3:0] gexp(input logic [3:0] q, s, c);
    gexp = (q & ~(c & ~s)) | (s & ~c);
  endfunction
  task tmr(input logic fw, which, sel);
    int len;
    len = (sel && (which ? fw : !fw)) ? 1 << `BCGIR_SHORT_EXP : 1 << `BCGIR_LONG_EXP;
    @(posedge clk) fwd <= fw;
    wreg(`BCGIR_OFS_CTRL, {20'h0, 2'b10, which & sel, !which & sel, 8'h00});
    @(posedge clk) begin
      ps <= !which;
      ss <= which;
    end
    @(posedge clk) begin
      ps <= 0;
      ss <= 0;
    end
    n = 0;
    while (!(which ? sexp : pexp)) begin
      @(posedge clk) n++;
      #1;
      if (n > 40000) begin
        mismatches++;
        conclude();
      end
    end
    chk(n >= len - 1 && n <= len + 1, 1);
    chk({errm, serr}, {fw && !pcx, !fw && !pcx});
    rreg(`BCGIR_OFS_CTRL, r);
    chk(r[10:8], {1'b1, fw & which & sel, !fw & !which & sel});
    rreg(`BCGIR_OFS_ISTAT, r);
    chk({r[1:0], irq}, 3'b111);
    wreg(`BCGIR_OFS_IMASK, 0);
    wreg(`BCGIR_OFS_IMASK, 0);
    chk(irq, 0);
    wreg(`BCGIR_OFS_ISTAT, 3);
    wreg(`BCGIR_OFS_CTRL, 32'h0000_0400);
    wreg(`BCGIR_OFS_IMASK, 3);
    rreg(`BCGIR_OFS_CTRL, r);
    chk({r[10], irq}, 0);
  endtask
  task conclude;
    $display("Counts: %0d checks, %0d mismatches", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ========
  // Main sequence
  initial begin
    v = $urandom(32'hd7e6d4ea);
    repeat (12) @(posedge clk);
    rst <= 0;
    rreg(`BCGIR_OFS_CTRL, r);
    chk(r, 0);
    rreg(`BCGIR_OFS_IRQB, r);
    chk(r, {16'h0, `BCGIR_PIN_FWD, `BCGIR_RST_BYTE});
    v = $urandom & 32'h0000_00ff;
    wreg(`BCGIR_OFS_IRQB, v);
    wreg(8'h40, 32'hffff_ffff);
    rreg(8'h40, r);
    chk(r, 0);
    @(posedge clk) fwd <= 0;
    rreg(`BCGIR_OFS_IRQB, r);
    chk(r, {16'h0, `BCGIR_PIN_REV, v[7:0]});
    $display("test bytes done");
    for (int i = 0; i < 32; i++) begin
      wreg(`BCGIR_OFS_CTRL, {25'h0, i[2], i[1:0], 4'h0});
      @(posedge clk) begin
        mhit <= !i[3];
        iohit <= i[3];
        fsec <= i[4];
        ioa <= 16'($urandom);
      end
      @(posedge clk) begin
        mhit <= 0;
        iohit <= 0;
      end
      #1 chk(claim, vexp(i[1:0], fsec, i[2], i[3], ioa));
    end
    $display("test vga done");
    for (int j = 0; j < 16; j++) begin
      wreg(`BCGIR_OFS_CTRL, {24'h0, j[0], 7'h0});
      @(posedge clk) begin
        sen <= j[3];
        mab <= 1;
        mrd <= j[1];
        tpos <= j[2];
      end
      @(posedge clk) mab <= 0;
      #1 chk(mrdata, (!j[0] && j[1]) ? `BCGIR_ALL_ONES : 0);
      chk({mdrop, tab, serr}, {!j[0] && !j[1], j[0] && j[2], j[0] && !j[2] && j[3]});
    end
    $display("test abort done");
    for (int k = 0; k < 12; k++) begin
      w = k == 0 ? 32'h0fff_f000 : $urandom;
      @(posedge clk) lvl <= w[3:0];
      wreg(`BCGIR_OFS_GPIO, w & 32'hffff_f000);
      eo = gexp(eo, w[19:16], w[15:12]);
      eoe = gexp(eoe, w[27:24], w[23:20]);
      rreg(`BCGIR_OFS_GPIO, r);
      chk(r, {w[3:0], eoe, 4'h0, eo, 16'h0});
      chk({go, goe}, {eo, eoe});
    end
    $display("test gpio done");
    @(posedge clk) dcd <= 1;
    wreg(`BCGIR_OFS_IMASK, 3);
    tmr(0, 0, 1);
    tmr(1, 1, 1);
    tmr(1, 0, 1);
    tmr(0, 1, 1);
    @(posedge clk) pcx <= 1;
    tmr(0, 0, 1);
    $display("test timers done");
    conclude();
  end
endmodule
